// [verilog/gcs_pkg.sv]
// package for the graphics config status and class registers
package gcs_pkg;
   // ==========================================================
   // register offsets (byte offsets in configuration space)
   localparam logic [7:0]  STATUS_OFFSET      = 8'h06;
   localparam logic [7:0]  REVISION_OFFSET    = 8'h08;
   localparam logic [7:0]  CLASS_OFFSET       = 8'h09;
   // ==========================================================
   // status word fields
   localparam int          STS_ERR_HI_POS     = 15;
   localparam int          STS_ERR_LO_POS     = 11;
   localparam int          STS_TIMING_HI_POS  = 10;
   localparam int          STS_TIMING_LO_POS  = 9;
   localparam int          STS_MPERR_POS      = 8;
   localparam int          STS_B2B_POS        = 7;
   localparam int          STS_UDF_POS        = 6;
   localparam int          STS_HS_POS         = 5;
   localparam int          STS_CAP_POS        = 4;
   localparam int          STS_INT_POS        = 3;
   localparam logic [15:0] STATUS_RESET       = 16'h0090;
   // ==========================================================
   // class code fields
   localparam logic [7:0]  BASE_CLASS_DISPLAY = 8'h03;
   localparam logic [7:0]  SUB_CLASS_VGA      = 8'h00;
   localparam logic [7:0]  SUB_CLASS_NON_VGA  = 8'h80;
   localparam logic [7:0]  PROG_IF_DISPLAY    = 8'h00;
   localparam logic [23:0] CLASS_RESET        = 24'h030000;
   localparam int          GCW_SEL_POS        = 1;
   // arbitrary revision value
   localparam logic [7:0]  REVISION_DEFAULT   = 8'h01;

   typedef struct packed {
      logic       valid;
      logic [7:0] offset;
   } gcs_req_type;

   typedef struct packed {
      logic        valid;
      logic [31:0] data;
   } gcs_rsp_type;
endpackage : gcs_pkg

// [verilog/gcs_class_sel.sv]
// class code assembly from the graphics control strap
`timescale 1ns/1ps
module gcs_class_sel (
   input  wire logic        non_vga_in,
   output logic      [23:0] class_code_out
);
   wire logic [7:0] sub_class_field;

   assign sub_class_field = non_vga_in ? gcs_pkg::SUB_CLASS_NON_VGA
                                       : gcs_pkg::SUB_CLASS_VGA;
   assign class_code_out  = {gcs_pkg::BASE_CLASS_DISPLAY, sub_class_field,
                             gcs_pkg::PROG_IF_DISPLAY};
endmodule : gcs_class_sel

// [verilog/gcs_regs.sv]
// read-only status, revision and class code registers of the graphics function
// Notes on behaviour
// - status bits 15..11 always read zero and ignore writes.
// - the select timing field in bits 10:9 is fixed at zero.
// - status bit 8 reads zero as no parity checking is done.
// - status bit 7 reads one to advertise back-to-back acceptance.
// - status bits 6 and 5 are constant zero.
// - status bit 4 reads one as a capability list exists at 34h.
// - status bit 3 mirrors pending interrupt; the line asserts only if not disabled.
// - the interrupt disable bit masks only the line and its assert message, never the status bit.
// - the status word is 16 bits, read-only, reset image 0090h.
// - an 8-bit read-only revision number, shared by functions 0 and 1.
// - class code has base class 03h and programming interface 00h.
// - the subclass byte is 00h or 80h by graphics control bit 1.
// - with interrupts disabled no interrupt line or assert message is sent.
`timescale 1ns/1ps
module gcs_regs #(
   parameter logic [7:0] REVISION = gcs_pkg::REVISION_DEFAULT
) (
   input  wire logic                 clock_in,
   input  wire logic                 arst_n_in,
   input  wire gcs_pkg::gcs_req_type cfg_req_in,
   input  wire logic                 int_pending_in,
   input  wire logic                 int_disable_in,
   input  wire logic [15:0]          graphics_control_word_in,
   output gcs_pkg::gcs_rsp_type      cfg_rsp_out,
   output logic                      int_line_out,
   output logic                      int_assert_msg_out,
   output logic                      int_deassert_msg_out
);
   // ==========================================================
   // state
   logic                 int_status_ff;
   logic                 line_ff;
   logic                 msg_state_ff;
   logic                 assert_msg_ff;
   logic                 deassert_msg_ff;
   logic [23:0]          class_ff;
   gcs_pkg::gcs_rsp_type rsp_ff;

   wire logic [15:0] status_word;
   wire logic        detected_parity_error;
   wire logic        signaled_system_error;
   wire logic        received_master_abort;
   wire logic        received_target_abort;
   wire logic        signaled_target_abort;
   wire logic [1:0]  select_timing_field;
   wire logic        master_parity_error_flag;
   wire logic        back_to_back_capable;
   wire logic        user_format_flag;
   wire logic        high_speed_capable;
   wire logic        capabilities_present;
   wire logic [2:0]  reserved_status;
   wire logic [23:0] class_code;
   wire logic [31:0] rd_data;
   wire logic        nxt_line;
   wire logic        hit_status;
   wire logic        hit_rev;

   // ==========================================================
   // decode
   gcs_class_sel u_class_sel (
      .non_vga_in     (graphics_control_word_in[gcs_pkg::GCW_SEL_POS]),
      .class_code_out (class_code)
   );

   // ==========================================================
   // status word assembly
   function automatic logic offset_hit(input logic [7:0] offset, input logic [7:0] target);
      return offset == target;
   endfunction : offset_hit

   // hardwired flags: no parity, no aborts, no system error reporting
   assign detected_parity_error    = 1'b0;
   assign signaled_system_error    = 1'b0;
   assign received_master_abort    = 1'b0;
   assign received_target_abort    = 1'b0;
   assign signaled_target_abort    = 1'b0;
   assign select_timing_field      = 2'h0;
   assign master_parity_error_flag = 1'b0;
   assign back_to_back_capable     = 1'b1;
   assign user_format_flag         = 1'b0;
   assign high_speed_capable       = 1'b0;
   assign capabilities_present     = 1'b1;
   assign reserved_status          = 3'h0;
   // only the interrupt status bit is live
   assign status_word = {detected_parity_error, signaled_system_error, received_master_abort,
                         received_target_abort, signaled_target_abort, select_timing_field,
                         master_parity_error_flag, back_to_back_capable, user_format_flag,
                         high_speed_capable, capabilities_present,
                         int_status_ff,
                         reserved_status};
   assign hit_status  = offset_hit(cfg_req_in.offset, gcs_pkg::STATUS_OFFSET);
   assign hit_rev     = offset_hit(cfg_req_in.offset, gcs_pkg::REVISION_OFFSET);
   // dword read at 08h returns revision in the low byte, class above
   assign rd_data     = hit_status ? {status_word, 16'h0000}
                      : hit_rev ? {class_ff, REVISION}
                      : 32'h0000_0000;
   assign nxt_line    = int_status_ff & ~int_disable_in;

   // ==========================================================
   // registers
   always_ff @(posedge clock_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         int_status_ff   <= 1'b0;
         line_ff         <= 1'b0;
         msg_state_ff    <= 1'b0;
         assert_msg_ff   <= 1'b0;
         deassert_msg_ff <= 1'b0;
         class_ff        <= gcs_pkg::CLASS_RESET;
         rsp_ff          <= '0;
      end else begin
         int_status_ff   <= int_pending_in;
         line_ff         <= nxt_line;
         // message edges are taken against the line's last value
         msg_state_ff    <= nxt_line;
         assert_msg_ff   <= nxt_line & ~msg_state_ff;
         deassert_msg_ff <= ~nxt_line & msg_state_ff;
         class_ff        <= class_code;
         rsp_ff.valid    <= cfg_req_in.valid;
         rsp_ff.data     <= cfg_req_in.valid ? rd_data : 32'h0000_0000;
      end
   end

   assign cfg_rsp_out          = rsp_ff;
   assign int_line_out         = line_ff;
   assign int_assert_msg_out   = assert_msg_ff;
   assign int_deassert_msg_out = deassert_msg_ff;

   // ==========================================================
   // assertions
   a_status_fixed: assert property (@(posedge clock_in) disable iff (!arst_n_in)
      (status_word & 16'hFFF7) == gcs_pkg::STATUS_RESET)
      else $error("status fixed bits wrong");
   a_status_read: assert property (@(posedge clock_in) disable iff (!arst_n_in)
      cfg_req_in.valid && hit_status |=> rsp_ff.valid && rsp_ff.data[31:27] == 5'h00
      && rsp_ff.data[26:25] == 2'h0 && rsp_ff.data[23] && rsp_ff.data[20])
      else $error("status read image wrong");
   a_reserved_zero: assert property (@(posedge clock_in) disable iff (!arst_n_in)
      cfg_req_in.valid && hit_status |=> rsp_ff.data[18:16] == 3'h0
      && rsp_ff.data[24] == 1'b0 && rsp_ff.data[22:21] == 2'h0)
      else $error("reserved status bits not zero");
   a_int_mirror: assert property (@(posedge clock_in) disable iff (!arst_n_in)
      ##1 int_status_ff == $past(int_pending_in))
      else $error("interrupt status not tracking");
   a_line_gated: assert property (@(posedge clock_in) disable iff (!arst_n_in)
      int_line_out |-> $past(int_status_ff) && !$past(int_disable_in))
      else $error("interrupt line asserted without cause");
   a_no_msg_dis: assert property (@(posedge clock_in) disable iff (!arst_n_in)
      int_disable_in |=> !int_assert_msg_out)
      else $error("assert message while disabled");
   a_rev_value: assert property (@(posedge clock_in) disable iff (!arst_n_in)
      cfg_req_in.valid && hit_rev |=> rsp_ff.data[7:0] == REVISION)
      else $error("revision value wrong");
   a_class_base: assert property (@(posedge clock_in) disable iff (!arst_n_in)
      class_ff[23:16] == 8'h03 && class_ff[7:0] == 8'h00)
      else $error("class base or interface wrong");
   a_subclass_sel: assert property (@(posedge clock_in) disable iff (!arst_n_in)
      graphics_control_word_in[1] ##1 graphics_control_word_in[1] |-> class_ff[15:8] == 8'h80)
      else $error("subclass not following strap");
   a_subclass_vga: assert property (@(posedge clock_in) disable iff (!arst_n_in)
      !graphics_control_word_in[gcs_pkg::GCW_SEL_POS] ##1
      !graphics_control_word_in[gcs_pkg::GCW_SEL_POS]
      |-> class_ff[15:8] == gcs_pkg::SUB_CLASS_VGA)
      else $error("subclass not VGA compatible");

   // ==========================================================
   // response timing and image
   a_rsp_taken: assert property (@(posedge clock_in) disable iff (!arst_n_in)
      cfg_req_in.valid |=> cfg_rsp_out.valid)
      else $error("read not answered one cycle later");
   a_rsp_idle: assert property (@(posedge clock_in) disable iff (!arst_n_in)
      !cfg_req_in.valid |=> !cfg_rsp_out.valid && cfg_rsp_out.data == 32'h0000_0000)
      else $error("response not idle without request");
   a_status_image: assert property (@(posedge clock_in) disable iff (!arst_n_in)
      cfg_req_in.valid && hit_status |=> cfg_rsp_out.data[15:0] == 16'h0000
      && (cfg_rsp_out.data[31:16] & 16'hFFF7) == gcs_pkg::STATUS_RESET)
      else $error("status word image wrong");
   a_int_read: assert property (@(posedge clock_in) disable iff (!arst_n_in)
      cfg_req_in.valid && hit_status |=> cfg_rsp_out.data[19] == $past(int_status_ff))
      else $error("interrupt status not read back");
   a_class_read: assert property (@(posedge clock_in) disable iff (!arst_n_in)
      cfg_req_in.valid && hit_rev |=> cfg_rsp_out.data[31:24] == gcs_pkg::BASE_CLASS_DISPLAY
      && cfg_rsp_out.data[15:8] == gcs_pkg::PROG_IF_DISPLAY)
      else $error("class code read wrong");
   a_sub_read: assert property (@(posedge clock_in) disable iff (!arst_n_in)
      cfg_req_in.valid && hit_rev |=> cfg_rsp_out.data[23:16] == $past(class_ff[15:8]))
      else $error("subclass read wrong");
   a_unmapped_zero: assert property (@(posedge clock_in) disable iff (!arst_n_in)
      cfg_req_in.valid && !hit_status && !hit_rev |=> cfg_rsp_out.data == 32'h0000_0000)
      else $error("unmapped offset not zero");

   // ==========================================================
   // interrupt line and messages
   a_int_pass: assert property (@(posedge clock_in) disable iff (!arst_n_in)
      int_disable_in |=> int_status_ff == $past(int_pending_in))
      else $error("interrupt status masked by disable");
   a_line_follow: assert property (@(posedge clock_in) disable iff (!arst_n_in)
      int_status_ff && !int_disable_in |=> int_line_out)
      else $error("interrupt line not asserted");
   a_line_clear: assert property (@(posedge clock_in) disable iff (!arst_n_in)
      !int_status_ff |=> !int_line_out)
      else $error("interrupt line without pending state");
   a_line_masked: assert property (@(posedge clock_in) disable iff (!arst_n_in)
      int_disable_in |=> !int_line_out)
      else $error("interrupt line asserted while disabled");
   a_assert_edge: assert property (@(posedge clock_in) disable iff (!arst_n_in)
      int_assert_msg_out |-> int_line_out && !$past(int_line_out))
      else $error("assert message not on line rise");
   a_deassert_edge: assert property (@(posedge clock_in) disable iff (!arst_n_in)
      int_deassert_msg_out |-> !int_line_out && $past(int_line_out))
      else $error("deassert message not on line fall");
   a_msg_exclusive: assert property (@(posedge clock_in) disable iff (!arst_n_in)
      !(int_assert_msg_out && int_deassert_msg_out))
      else $error("both interrupt messages at once");

   // ==========================================================
   // covers
   c_status_read: cover property (@(posedge clock_in) cfg_req_in.valid && hit_status);
   c_rev_read:    cover property (@(posedge clock_in) cfg_req_in.valid && hit_rev);
   c_int_line:    cover property (@(posedge clock_in)
      int_assert_msg_out ##[1:20] int_deassert_msg_out);
   c_masked:      cover property (@(posedge clock_in) int_status_ff && int_disable_in);
   c_non_vga:     cover property (@(posedge clock_in) class_ff[15:8] == 8'h80);
endmodule : gcs_regs

// [verif/gcs_host_model.sv]
// host configuration read requester model
`timescale 1ns/1ps
module gcs_host_model (
   input  wire gcs_pkg::gcs_rsp_type rsp_in,
   input  wire logic                 clock_in,
   output gcs_pkg::gcs_req_type      req_out
);
   // =====================================
   // one read; offset inverted once released
   initial req_out = '{valid: 1'h0, offset: 8'hFF};
   task automatic rd(input logic [7:0] off, output logic [31:0] d, output logic ok);
      ok = 1'h0;
      d = 32'h0;
      @(negedge clock_in);
      req_out = '{valid: 1'h1, offset: off};
      for (int i = 0; i < 4 && !ok; i++) begin
         @(negedge clock_in);
         req_out = '{valid: 1'h0, offset: ~off};
         if (rsp_in.valid === 1'h1) begin
            ok = 1'h1;
            d = rsp_in.data;
         end
      end
   endtask : rd
endmodule : gcs_host_model

// [verif/tb_top.sv]
// self-checking bench for the graphics config status and class registers
`timescale 1ns/1ps
module tb_top;
   typedef struct packed {
      logic [7:0] off; logic [15:0] gcw; logic pend; logic dis; logic [31:0] data; logic line;
   } gcs_row_type;
   localparam logic [7:0] REV = 8'h5A;
   logic                 clock_in = 1'h0;
   logic                 arst_n_in = 1'h0;
   logic                 pend = 1'h0;
   logic                 dis = 1'h0;
   logic [15:0]          gcw = 16'h0;
   logic [31:0]          rd_data;
   logic                 rd_ok, line, am, dm;
   gcs_pkg::gcs_req_type req;
   gcs_pkg::gcs_rsp_type rsp;
   int                   miscompares = 0;
   int                   samples_checked = 0;
   int                   na, nd;
   gcs_row_type rows [7] = '{
      '{8'h06, 16'hFFFD, 1'h0, 1'h0, 32'h0090_0000, 1'h0},
      '{8'h06, 16'h0000, 1'h1, 1'h0, 32'h0098_0000, 1'h1},
      '{8'h06, 16'h0000, 1'h1, 1'h1, 32'h0098_0000, 1'h0},
      '{8'h08, 16'hFFFD, 1'h0, 1'h1, {24'h030000, REV}, 1'h0},
      '{8'h08, 16'h0002, 1'h0, 1'h0, {24'h038000, REV}, 1'h0},
      '{8'h09, 16'h0002, 1'h0, 1'h0, 32'h0, 1'h0},
      '{8'h0C, 16'h0002, 1'h1, 1'h0, 32'h0, 1'h1}};
   always #2.5 clock_in = ~clock_in;
   gcs_regs #(.REVISION(REV)) gcs_regs_i (.clock_in(clock_in), .arst_n_in(arst_n_in),
      .cfg_req_in(req), .int_pending_in(pend), .int_disable_in(dis),
      .graphics_control_word_in(gcw), .cfg_rsp_out(rsp), .int_line_out(line),
      .int_assert_msg_out(am), .int_deassert_msg_out(dm));
   gcs_host_model gcs_host_model_i (.rsp_in(rsp), .clock_in(clock_in), .req_out(req));
   // =====================================
   // checking helpers
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         miscompares++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task automatic pulses(input int cycles);
      na = 0;
      nd = 0;
      repeat (cycles) begin
         @(negedge clock_in);
         na += int'(am === 1'h1);
         nd += int'(dm === 1'h1);
      end
   endtask : pulses
   task automatic stop_test;
      $display("checks %0d miscompares %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : stop_test
   // =====================================
   // main sequence
   initial begin
      repeat (12) @(negedge clock_in);
      arst_n_in = 1'h1;
      foreach (rows[i]) begin
         gcw = rows[i].gcw;
         pend = rows[i].pend;
         dis = rows[i].dis;
         repeat (3) @(negedge clock_in);
         gcs_host_model_i.rd(rows[i].off, rd_data, rd_ok);
         check("answer", 32'(rd_ok), 32'h1);
         check("data", rd_data, rows[i].data);
         check("errs", 32'(rd_data[31:25]), 32'(rows[i].data[31:25]));
         check("b2b", 32'(rd_data[24:23]), 32'(rows[i].data[24:23]));
         check("caps", 32'(rd_data[22:20]), 32'(rows[i].data[22:20]));
         check("rsvd", 32'(rd_data[18:16]), 32'(rows[i].data[18:16]));
         check("line", 32'(line), 32'(rows[i].line));
      end
      pend = 1'h0;
      pulses(4);
      check("deassert msgs", 32'(nd), 32'h1);
      dis = 1'h1;
      pend = 1'h1;
      pulses(4);
      check("masked msgs", 32'(na), 32'h0);
      dis = 1'h0;
      pulses(4);
      check("assert msgs", 32'(na), 32'h1);
      arst_n_in = 1'h0;
      pend = 1'h0;
      @(negedge clock_in);
      check("line in reset", 32'(line), 32'h0);
      arst_n_in = 1'h1;
      gcs_host_model_i.rd(8'h06, rd_data, rd_ok);
      check("answer after reset", 32'(rd_ok), 32'h1);
      check("status after reset", rd_data, 32'h0090_0000);
      stop_test();
   end
endmodule : tb_top
